//--- logic/srs_pkg.sv
// shared constants and types of the system reset sequencer
package srs_pkg;
  // sequence lengths
  localparam int SRS_OSC_CYCLES = 50;
  localparam int SRS_SYS_CYCLES = 16;
  localparam int SRS_PIN_MIN_LOW = 4;
  localparam int SRS_CNT_W = 6;
  // reset vector location in program memory
  localparam logic [15:0] SRS_VEC_ADDR_HI = 16'h0002;
  localparam logic [15:0] SRS_VEC_ADDR_LO = 16'h0003;
  // register byte offsets
  localparam logic [3:0] SRS_REG_STATUS = 4'h0;
  localparam logic [3:0] SRS_REG_CTRL = 4'h4;
  localparam logic [3:0] SRS_REG_STATE = 4'h8;
  // status field positions
  localparam int SRS_ST_POR = 7;
  localparam int SRS_ST_STOP = 6;
  localparam int SRS_ST_WDT = 5;
  localparam int SRS_ST_EXT = 4;
  localparam int SRS_ST_FLT = 3;
  localparam int SRS_ST_ROLE = 0;
  // control field positions
  localparam int SRS_CT_DBG = 0;
  localparam int SRS_CT_WDOPT = 1;
  localparam int SRS_CT_BOSTOP = 2;
  // reset values
  localparam logic SRS_WDOPT_RST = 1'b1;
  localparam logic SRS_BOSTOP_RST = 1'b0;
  localparam logic SRS_ROLE_RST = 1'b0;
  // sequence states, gray along the path
  typedef enum logic [1:0] {
    SRS_RUN = 2'b00,
    SRS_OPT = 2'b01,
    SRS_SYS = 2'b11,
    SRS_PIN = 2'b10
  } srs_state_t;
endpackage : srs_pkg

//--- logic/srs_pin_if.sv
// signals between the sequencer and its reset pin filter
`timescale 1ns/100ps
interface srs_pin_if;
  logic pin_low;
  logic bypass;
  logic filt_low;
  modport filt (input pin_low, input bypass, output filt_low);
  modport user (output pin_low, output bypass, input filt_low);
endinterface : srs_pin_if

//--- logic/srs_pin_filter.sv
// digital noise filter on the reset pin
`timescale 1ns/100ps
module srs_pin_filter
  import srs_pkg::*;
#(
  parameter int MIN_LOW = SRS_PIN_MIN_LOW
) (
  input wire logic clk,
  input wire logic nrst,
  srs_pin_if.filt pin
);
  typedef struct packed {
    logic [3:0] cnt;
    logic low;
  } srs_filt_t;

  srs_filt_t r;
  srs_filt_t next_r;

  generate
    if (MIN_LOW < 1 || MIN_LOW > 15) begin : g_bad
      $error("pin filter length out of range");
    end
  endgenerate

  // count consecutive low samples, any high sample restarts
  always_comb begin
    next_r = r;
    if (!pin.pin_low) begin
      next_r.cnt = 4'h0;
      next_r.low = 1'b0;
    end else if (r.cnt == 4'(MIN_LOW - 1)) begin
      next_r.low = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // no system clock in stop mode, so the raw level is used
  assign pin.filt_low = pin.bypass ? pin.pin_low : r.low;
endmodule : srs_pin_filter

//--- logic/srs_sequencer.sv
// system reset sequencer with wishbone status and control registers
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Function
// - any system reset holds core and peripherals for 66 oscillator cycles
// - reset start turns all gpio to inputs, pull-ups off
// - pwm outputs float first, then driven to programmed off level
// - first 50 oscillator cycles load option bits, then system clock runs
// - sixteen more system clock cycles idle, then internal reset released
// - cpu and peripherals idle in reset; oscillators keep running
// - registers with reset values load them during reset
// - after release fetch reset vector at 0002h and 0003h
// - power-on or brown-out beats every other simultaneous source
// - sources allowed depend on normal or stop mode
// - debugger reset spares debugger, request bit self-clears, sets por cause
// - power-on sequence, also after brown-out, sets por cause
// - brown-out in stop mode follows its own option
// - watchdog resets only when its option is 1; sets watchdog cause
// - pin low at least 4 cycles starts reset; held low keeps reset
// - pin held past timeout: leave reset 16 cycles after release
// - pin released early: device keeps driving it low until done
// - pin driven low open-drain during any reset, released after delay
// - reset pin filter bypassed in stop mode
// - pin-started reset sets external cause
// - fault detection forces reset and sets fault cause
// - cause bits rewritten on each reset start; power loss mid-sequence only sets por; several may be set
// - role select 0 keeps reset input, 1 makes pin fault input
module srs_sequencer
  import srs_pkg::*;
#(
  parameter int OSC_CYCLES = SRS_OSC_CYCLES,
  parameter int SYS_CYCLES = SRS_SYS_CYCLES,
  parameter int PIN_MIN_LOW = SRS_PIN_MIN_LOW
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic osc_tick,
  input wire logic power_on,
  input wire logic brownout_detect,
  input wire logic watchdog_timeout,
  input wire logic fault_detect,
  input wire logic stop_mode,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic fault_pin_in,
  output logic in_reset,
  output logic debugger_reset,
  output logic sys_clk_run,
  output logic option_load,
  output logic load_defaults,
  output logic osc_keep_run,
  output logic gpio_force_input,
  output logic pullup_disable,
  output logic pwm_hiz,
  output logic pwm_force_off,
  output logic vector_fetch,
  output logic [15:0] vector_addr_hi,
  output logic [15:0] vector_addr_lo,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  typedef struct packed {
    srs_state_t st;
    logic [SRS_CNT_W-1:0] cnt;
    logic [7:0] status;
    logic dbg_req;
    logic dbg_only;
    logic wd_opt;
    logic bo_opt;
    logic vec;
    logic ack;
    logic [31:0] rdat;
    logic held;
    logic [SRS_CNT_W-1:0] hi_len;
  } srs_regs_t;

  srs_regs_t r;
  srs_regs_t next_r;
  srs_pin_if pin_bus ();
  logic bo_any;
  logic por_any;
  logic pin_trig;
  logic wd_trig;
  logic dbg_trig;
  logic flt_trig;
  logic bus_go;
  logic wr_ctrl;
  logic wr_stat;

  generate
    if (OSC_CYCLES < 1 || OSC_CYCLES >= (1 << SRS_CNT_W)
        || SYS_CYCLES < 1 || SYS_CYCLES >= (1 << SRS_CNT_W)) begin : g_bad
      $error("sequence counts out of range");
    end
  endgenerate

  srs_pin_filter #(
    .MIN_LOW(PIN_MIN_LOW)
  ) u_filter (
    .clk(clk),
    .nrst(nrst),
    .pin(pin_bus)
  );

  // reset pin feeds the filter; stop mode bypasses it
  assign pin_bus.pin_low = !rst_pin_in;
  assign pin_bus.bypass = stop_mode;

  // source qualification per operating mode
  assign bo_any = brownout_detect && (!stop_mode || r.bo_opt);
  assign por_any = power_on || bo_any;
  assign pin_trig = pin_bus.filt_low && !r.status[SRS_ST_ROLE];
  assign wd_trig = watchdog_timeout && r.wd_opt && !stop_mode;
  assign dbg_trig = r.dbg_req && !stop_mode;
  assign flt_trig = fault_detect;

  // bus strobes
  assign bus_go = wb_cyc_i && wb_stb_i && !r.ack;
  assign wr_ctrl = bus_go && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == SRS_REG_CTRL;
  assign wr_stat = bus_go && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == SRS_REG_STATUS;

  // sequence, causes and register file
  always_comb begin
    next_r = r;
    next_r.vec = 1'b0;
    next_r.ack = bus_go;
    case (r.st)
      SRS_RUN: begin
        if (por_any || pin_trig || wd_trig || dbg_trig || flt_trig) begin
          next_r.st = SRS_OPT;
          next_r.cnt = '0;
          next_r.dbg_only = dbg_trig && !por_any && !pin_trig
                            && !wd_trig && !flt_trig;
          // causes rewritten on each event, role kept
          next_r.status[7:1] = 7'h00;
          next_r.status[SRS_ST_POR] = por_any || dbg_trig;
          next_r.status[SRS_ST_WDT] = wd_trig;
          next_r.status[SRS_ST_EXT] = pin_trig || wd_trig || dbg_trig
                                      || flt_trig;
          next_r.status[SRS_ST_FLT] = flt_trig;
        end
      end
      SRS_OPT: begin
        // oscillator paced option load
        if (osc_tick) begin
          if (r.cnt == SRS_CNT_W'(OSC_CYCLES - 1)) begin
            next_r.st = SRS_SYS;
            next_r.cnt = '0;
          end else begin
            next_r.cnt = r.cnt + 1'b1;
          end
        end
      end
      SRS_SYS: begin
        if (r.cnt == SRS_CNT_W'(SYS_CYCLES - 1)) begin
          next_r.st = SRS_PIN;
          next_r.cnt = SRS_CNT_W'(SYS_CYCLES - 1);
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      SRS_PIN: begin
        // pin let go: check whether someone still holds it
        if (!rst_pin_in) begin
          next_r.cnt = '0;
        end else if (r.cnt == SRS_CNT_W'(SYS_CYCLES - 1)) begin
          next_r.st = SRS_RUN;
          next_r.vec = 1'b1;
          next_r.dbg_only = 1'b0;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      default: begin
        next_r.st = SRS_OPT;
        next_r.cnt = '0;
      end
    endcase
    // power loss restarts the whole sequence at any point
    if (por_any && r.st != SRS_RUN) begin
      next_r.st = SRS_OPT;
      next_r.cnt = '0;
      next_r.dbg_only = 1'b0;
      next_r.status[SRS_ST_POR] = 1'b1;
    end
    // debugger request self-clears once reset runs
    if (r.st == SRS_OPT) begin
      next_r.dbg_req = 1'b0;
    end
    // pin high run after a hold, watched by the exit checks
    if (r.st != SRS_PIN) begin
      next_r.held = 1'b0;
      next_r.hi_len = '0;
    end else if (!rst_pin_in) begin
      next_r.held = 1'b1;
      next_r.hi_len = '0;
    end else if (r.hi_len != '1) begin
      next_r.hi_len = r.hi_len + 1'b1;
    end
    // control and role writes
    if (wr_ctrl) begin
      next_r.dbg_req = wb_dat_i[SRS_CT_DBG] | next_r.dbg_req;
      next_r.wd_opt = wb_dat_i[SRS_CT_WDOPT];
      next_r.bo_opt = wb_dat_i[SRS_CT_BOSTOP];
    end
    if (wr_stat) begin
      next_r.status[SRS_ST_ROLE] = wb_dat_i[SRS_ST_ROLE];
    end
    // read mux, unmapped reads zero
    next_r.rdat = 32'h0000_0000;
    if (bus_go && !wb_we_i) begin
      case (wb_adr_i)
        SRS_REG_STATUS: next_r.rdat = {24'h000000, r.status};
        SRS_REG_CTRL: next_r.rdat = {29'h0, r.bo_opt, r.wd_opt, r.dbg_req};
        SRS_REG_STATE: next_r.rdat = {24'h000000, 2'b00, r.cnt};
        default: next_r.rdat = 32'h0000_0000;
      endcase
      if (wb_adr_i == SRS_REG_STATE) begin
        next_r.rdat[9:8] = r.st;
      end
    end
  end

  // state registers, defaults on power-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r.st <= SRS_OPT;
      r.cnt <= '0;
      r.status <= 8'h80;
      r.dbg_req <= 1'b0;
      r.dbg_only <= 1'b0;
      r.wd_opt <= SRS_WDOPT_RST;
      r.bo_opt <= SRS_BOSTOP_RST;
      r.vec <= 1'b0;
      r.ack <= 1'b0;
      r.rdat <= 32'h0000_0000;
      r.held <= 1'b0;
      r.hi_len <= '0;
    end else begin
      r <= next_r;
    end
  end

  // reset side effects on the rest of the chip
  assign in_reset = r.st != SRS_RUN;
  assign debugger_reset = in_reset && !r.dbg_only;
  assign sys_clk_run = r.st != SRS_OPT;
  assign option_load = r.st == SRS_OPT;
  assign load_defaults = in_reset;
  assign osc_keep_run = 1'b1;
  assign gpio_force_input = in_reset;
  assign pullup_disable = in_reset;
  assign pwm_hiz = r.st == SRS_OPT;
  assign pwm_force_off = r.st == SRS_SYS || r.st == SRS_PIN;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = r.st == SRS_OPT || r.st == SRS_SYS;
  assign fault_pin_in = r.status[SRS_ST_ROLE] && !rst_pin_in;
  assign vector_fetch = r.vec;
  assign vector_addr_hi = SRS_VEC_ADDR_HI;
  assign vector_addr_lo = SRS_VEC_ADDR_LO;
  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // sequence, pin and cause checks
  a_por_restart: assert property (por_any |=> r.st == SRS_OPT)
    else $error("power loss did not restart sequence");

  a_opt_done: assert property (r.st == SRS_OPT && osc_tick
      && !por_any && r.cnt == SRS_CNT_W'(OSC_CYCLES - 1)
      |=> r.st == SRS_SYS)
    else $error("option phase did not end on count");

  a_opt_hold: assert property (r.st == SRS_OPT && !osc_tick
      && !por_any |=> r.st == SRS_OPT && $stable(r.cnt))
    else $error("option phase advanced without oscillator");

  a_sys_len: assert property ($rose(r.st == SRS_SYS)
      && !por_any |-> (r.st == SRS_SYS) [*8])
    else $error("system clock phase cut short");

  a_sys_exit: assert property (r.st == SRS_SYS && !por_any
      && r.cnt == SRS_CNT_W'(SYS_CYCLES - 1)
      |=> r.st == SRS_PIN && !rst_pin_oe)
    else $error("system clock phase did not end on count");

  a_pin_drive: assert property (rst_pin_oe |-> !rst_pin_out
      && in_reset)
    else $error("pin driven outside reset");

  a_pin_exit: assert property (r.st == SRS_PIN && r.held
      && rst_pin_in && !por_any
      && r.hi_len == SRS_CNT_W'(SYS_CYCLES - 1) |=> r.st == SRS_RUN)
    else $error("no exit 16 cycles after pin release");

  a_pin_early: assert property (r.st == SRS_PIN && r.held
      && !por_any && r.hi_len < SRS_CNT_W'(SYS_CYCLES - 1)
      |=> r.st == SRS_PIN)
    else $error("reset left before pin release count");

  a_wdt_gate: assert property (r.st == SRS_RUN && watchdog_timeout
      && !r.wd_opt && !por_any && !pin_trig && !dbg_trig && !flt_trig
      |=> r.st == SRS_RUN)
    else $error("watchdog reset with option off");

  a_stop_gate: assert property (r.st == SRS_RUN && stop_mode
      && !por_any && !pin_trig && !flt_trig |=> r.st == SRS_RUN)
    else $error("stop mode reset from a masked source");

  a_dbg_clear: assert property (r.st == SRS_OPT && !wr_ctrl
      |=> !r.dbg_req)
    else $error("debugger request not cleared");

  a_dbg_spare: assert property (r.dbg_only |-> in_reset
      && !debugger_reset)
    else $error("debugger reset by its own request");

  a_ext_cause: assert property (r.st == SRS_RUN && pin_trig
      |=> r.status[SRS_ST_EXT] && !r.status[SRS_ST_STOP])
    else $error("external cause not recorded");

  a_flt_cause: assert property (r.st == SRS_RUN && flt_trig
      |=> in_reset && r.status[SRS_ST_FLT])
    else $error("fault did not force reset");

  a_vec_fetch: assert property ($fell(in_reset) |-> vector_fetch)
    else $error("no vector fetch at release");

  a_pwm_order: assert property ($rose(r.st == SRS_SYS)
      |-> $past(pwm_hiz) && pwm_force_off)
    else $error("pwm off level not after float");

  c_por_seq: cover property (r.st == SRS_PIN ##1 r.st == SRS_RUN);
  c_pin_hold: cover property (r.st == SRS_PIN && !rst_pin_in);
  c_wdt_rst: cover property (r.st == SRS_RUN && wd_trig);
  c_dbg_rst: cover property (r.st == SRS_RUN && dbg_trig);
  c_por_again: cover property (r.st != SRS_RUN && por_any);
endmodule : srs_sequencer

//--- verif/srs_board_model.sv
// board side of the shared open-drain reset line
`timescale 1ns/100ps
module srs_board_model (
  input wire logic dev_pin_out,
  input wire logic dev_pin_oe,
  input wire logic ext_hold_low,
  output logic pin_level
);
  // pull-up wins unless the device or a board part sinks the line
  assign pin_level = ((dev_pin_oe && !dev_pin_out) || ext_hold_low)
    ? 1'b0 : 1'b1;
endmodule : srs_board_model

//--- verif/test_system_reset_sequencer.sv
// self-checking bench for the system reset sequencer
`timescale 1ns/100ps
module test_system_reset_sequencer import srs_pkg::*; ();
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic osc_tick = 1'b0;
  logic power_on = 1'b0;
  logic brownout_detect = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic fault_detect = 1'b0;
  logic stop_mode = 1'b0;
  logic ext_low = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [15:0] vector_addr_hi, vector_addr_lo;
  logic rst_pin_in, rst_pin_out, rst_pin_oe, fault_pin_in, in_reset;
  logic debugger_reset, sys_clk_run, option_load, load_defaults;
  logic osc_keep_run, gpio_force_input, pullup_disable, pwm_hiz;
  logic pwm_force_off, vector_fetch, wb_ack_o;
  logic [1:0] div = 2'h0;
  int cycles = 0;
  int bad_count = 0;
  int num_checks = 0;

  srs_sequencer u_srs_sequencer (.clk, .nrst, .osc_tick, .power_on,
    .brownout_detect, .watchdog_timeout, .fault_detect, .stop_mode,
    .rst_pin_in, .rst_pin_out, .rst_pin_oe, .fault_pin_in, .in_reset,
    .debugger_reset, .sys_clk_run, .option_load, .load_defaults,
    .osc_keep_run, .gpio_force_input, .pullup_disable, .pwm_hiz,
    .pwm_force_off, .vector_fetch, .vector_addr_hi, .vector_addr_lo,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);

  srs_board_model u_srs_board_model (.dev_pin_out(rst_pin_out),
    .dev_pin_oe(rst_pin_oe), .ext_hold_low(ext_low),
    .pin_level(rst_pin_in));

  // clock, oscillator tick every third cycle, hang limit
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    osc_tick <= (div == 2'h2);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wb_io(input logic we, input logic [3:0] adr,
      input logic [31:0] dat, output logic [31:0] rd);
    int n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) check("wb_ack", 0, 1);
  endtask : wb_io

  // one-cycle pulse on brownout, watchdog, fault
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    {brownout_detect, watchdog_timeout, fault_detect} <= m;
    @(posedge clk);
    {brownout_detect, watchdog_timeout, fault_detect} <= 3'h0;
  endtask : pulse

  task automatic quiet;
    repeat (8) @(posedge clk);
    #1;
    check("no_reset", in_reset, 0);
  endtask : quiet

  // follows one whole sequence and judges each phase
  task automatic run_seq(input logic [7:0] st);
    int k = 0;
    int n = 0;
    int m = 0;
    logic [31:0] rd;
    #1;
    while (in_reset !== 1'b1 && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    check("in_reset", in_reset, 1);
    check("gpio", {gpio_force_input, pullup_disable}, 2'h3);
    check("pwm_hiz", {pwm_hiz, sys_clk_run}, 2'h2);
    check("pin_low", rst_pin_in, 0);
    check("dbg_rst", {debugger_reset, load_defaults},
      {st != 8'h90, 1'b1});
    while (option_load === 1'b1 && k < 2000) begin
      if (osc_tick) n++;
      @(posedge clk);
      #1;
      k++;
    end
    check("osc_cnt", n, SRS_OSC_CYCLES);
    check("clk_on", {sys_clk_run, pwm_force_off, osc_keep_run}, 3'h7);
    while (rst_pin_oe === 1'b1 && k < 2000) begin
      m++;
      @(posedge clk);
      #1;
      k++;
    end
    check("sys_cnt", m, SRS_SYS_CYCLES);
    while (in_reset === 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    check("fetch", vector_fetch, 1);
    check("vec", {vector_addr_hi, vector_addr_lo}, 32'h00020003);
    wb_io(1'b0, SRS_REG_STATUS, 32'h0, rd);
    check("status", rd[7:0], st);
  endtask : run_seq

  task automatic t_basic;
    logic [31:0] rd;
    run_seq(8'h80);
    wb_io(1'b0, SRS_REG_CTRL, 32'h0, rd);
    check("ctrl", rd[7:0], 8'h02);
    pulse(3'h1);
    run_seq(8'h18);
    pulse(3'h2);
    run_seq(8'h30);
    wb_io(1'b1, SRS_REG_CTRL, 32'h00, rd);
    pulse(3'h2);
    quiet();
    wb_io(1'b1, SRS_REG_CTRL, 32'h03, rd);
    run_seq(8'h90);
    wb_io(1'b0, SRS_REG_CTRL, 32'h0, rd);
    check("dbg_clr", rd[0], 0);
    $display("test internal sources done");
  endtask : t_basic

  task automatic t_pin;
    int n = 0;
    logic [31:0] rd;
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (3) @(posedge clk);
    ext_low <= 1'b0;
    quiet();
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk);
    ext_low <= 1'b0;
    run_seq(8'h10);
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (400) @(posedge clk);
    #1;
    check("held", in_reset, 1);
    @(posedge clk);
    ext_low <= 1'b0;
    #1;
    while (in_reset === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
      #1;
    end
    check("release", n, SRS_SYS_CYCLES);
    wb_io(1'b1, SRS_REG_STATUS, 32'h01, rd);
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("fault_pin", {fault_pin_in, in_reset}, 2'h2);
    @(posedge clk);
    ext_low <= 1'b0;
    wb_io(1'b1, SRS_REG_STATUS, 32'h00, rd);
    wb_io(1'b0, 4'hC, 32'h0, rd);
    check("unmapped", rd, 0);
    $display("test reset pin done");
  endtask : t_pin

  task automatic t_stop;
    logic [31:0] rd;
    @(posedge clk);
    stop_mode <= 1'b1;
    pulse(3'h2);
    quiet();
    pulse(3'h4);
    quiet();
    wb_io(1'b1, SRS_REG_CTRL, 32'h06, rd);
    pulse(3'h4);
    run_seq(8'h80);
    @(posedge clk);
    ext_low <= 1'b1;
    @(posedge clk);
    ext_low <= 1'b0;
    run_seq(8'h10);
    pulse(3'h1);
    repeat (20) @(posedge clk);
    power_on <= 1'b1;
    @(posedge clk);
    power_on <= 1'b0;
    run_seq(8'h98);
    @(posedge clk);
    stop_mode <= 1'b0;
    $display("test stop mode done");
  endtask : t_stop

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // reset, then every scenario in turn
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_basic();
    t_pin();
    t_stop();
    close_out();
  end
endmodule : test_system_reset_sequencer
